// ==== hw/uart_pkg.sv ====
// Package with register map, field layout and types of the serial port block
//
// Contract
// - Two-bit timer mode field picks mode 0..3 from high and low bits; the code counts timer 1 only in mode 2, other modes stop it.
// - Modes 1 and 3: rate is half timer 1 overflow, full when doubled.
// - Mode 2: rate is quarter clock, half clock when doubled.
// - Baud doubling is power control bit 7; other seven bits unused.
// - Serial control top two bits choose UART mode 0..3.
// - Modes 2/3 with filter set: accept frame only if ninth bit is one.
// - Receiver accepts data only while receive enable is one.
// - Modes 2/3: transmitter sends transmit ninth bit as extra data bit.
// - Modes 2/3: receiver stores extra bit into receive ninth bit field.
// - Frame sent: set transmit done flag and raise interrupt; software clears.
// - Frame received: set receive done flag and raise interrupt; software clears.
// - Timer 1 reload is 256 minus K*clock over 384*rate, K 1 or 2; the code uses 32*rate.
// - Timer mode 0x20 gives timer 1 mode 2; serial 0x50 gives mode 1 receiving.
package uart_pkg;
  localparam logic [11:0] power_control_addr = 12'h87 << 2;
  localparam logic [11:0] timer_mode_select_addr = 12'h89 << 2;
  localparam logic [11:0] serial_control_addr = 12'h98 << 2;
  localparam logic [11:0] timer1_reload_addr = 12'h100;
  localparam logic [11:0] tx_data_addr = 12'h104;
  localparam logic [11:0] rx_data_addr = 12'h108;
  localparam logic [11:0] irq_status_addr = 12'h10c;
  localparam logic [11:0] irq_mask_addr = 12'h110;
  localparam logic [11:0] timer1_ctrl_addr = 12'h114;
  localparam int baud_double_bit = 7;
  localparam int t1_mode_hi_bit = 5;
  localparam int t1_mode_lo_bit = 4;
  localparam int mode_hi_bit = 7;
  localparam int mode_lo_bit = 6;
  localparam int filter_bit = 5;
  localparam int rx_enable_bit = 4;
  localparam int tx_ninth_pos = 3;
  localparam int rx_ninth_pos = 2;
  localparam int tx_done_pos = 1;
  localparam int rx_done_pos = 0;
  localparam logic [7:0] reg8_reset = 8'h00;
  localparam logic [7:0] reload_reset = 8'h00;
  localparam logic [1:0] irq_reset = 2'h0;
  localparam int t1_mode2 = 2;
  localparam int uart_mode0 = 0;
  localparam int uart_mode1 = 1;
  localparam int uart_mode2 = 2;
  localparam int uart_mode3 = 3;
  // Sample ticks per bit; 16 for modes 1..3, two clocks per bit in mode 0
  // so that shift_clk has a falling and a rising edge inside every bit
  localparam logic [4:0] oversample = 5'h10;
  localparam logic [4:0] half_bit = 5'h08;
  localparam logic [4:0] shift_ticks = 5'h02;
  localparam logic [3:0] bits_mode0 = 4'h8;
  localparam logic [3:0] bits_mode1 = 4'ha;
  localparam logic [3:0] bits_mode23 = 4'hb;
  localparam logic [3:0] mode2_div_slow = 4'h4;
  localparam logic [3:0] mode2_div_fast = 4'h2;
  localparam real t1_ref_clock_mhz = 88.4736;
  localparam int t1_ref_divisor = 384;
  localparam int t1_reload_span = 256;

  typedef struct packed {
    logic mode_hi;
    logic mode_lo;
    logic multiproc_filter;
    logic rx_enable;
    logic tx_ninth_bit;
    logic rx_ninth_bit;
    logic tx_done_flag;
    logic rx_done_flag;
  } serial_ctrl_type;

  typedef struct packed {
    logic [7:0] data;
    logic ninth;
  } frame_type;
endpackage

// ==== hw/uart_rate_gen.sv ====
// Bit-rate tick generator: timer 1 auto-reload and serial rate selection
`timescale 1ns/1ps
module uart_rate_gen (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic timer1_run,
  input wire logic [1:0] timer1_mode,
  input wire logic [7:0] timer1_reload_high,
  input wire logic [1:0] uart_mode,
  input wire logic baud_double,
  output logic tick
);
  import uart_pkg::*;
  logic [7:0] count_q;
  logic ovf_q;
  logic half_q;
  logic [3:0] div_q;
  logic [3:0] div_lim;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      count_q <= reload_reset;
      ovf_q <= 1'b0;
    end else begin
      ovf_q <= 1'b0;
      if (timer1_run && timer1_mode == 2'(t1_mode2)) begin
        if (count_q == 8'hff) begin
          count_q <= timer1_reload_high;
          ovf_q <= 1'b1;
        end else begin
          count_q <= count_q + 8'h01;
        end
      end
    end
  end

  // Overflows halve unless doubled
  always_ff @(posedge sys_clk) begin
    if (reset) half_q <= 1'b0;
    else if (ovf_q) half_q <= ~half_q;
  end

  assign div_lim = baud_double ? mode2_div_fast : mode2_div_slow;

  always_ff @(posedge sys_clk) begin
    if (reset) div_q <= 4'h0;
    else if (div_q >= div_lim - 4'h1) div_q <= 4'h0;
    else div_q <= div_q + 4'h1;
  end

  // The tick is a sample tick; the core divides by its own oversample count
  always_comb begin
    unique case (uart_mode)
      2'(uart_mode2): tick = (div_q == 4'h0);
      2'(uart_mode0): tick = 1'b1;
      default: tick = ovf_q && (baud_double || half_q);
    endcase
  end
endmodule // uart_rate_gen

// ==== hw/uart_timer1_baud.sv ====
// Serial port with timer 1 bit-rate generator and APB register slave
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module uart_timer1_baud (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  output logic txd,
  output logic shift_clk,
  output logic irq
);
  import uart_pkg::*;

  typedef enum logic [1:0] {tx_idle, tx_shift} tx_state_type;
  typedef enum logic [1:0] {rx_idle, rx_start, rx_data} rx_state_type;

  logic [7:0] power_ctrl_reg_q;
  logic [7:0] timer_mode_reg_q;
  serial_ctrl_type serial_ctrl_reg_q;
  logic [7:0] reload_q;
  logic timer1_run_q;
  logic [7:0] rx_buf_q;
  logic [1:0] irq_status_q;
  logic [1:0] irq_mask_q;
  logic tick;
  logic [1:0] uart_mode;
  logic nine_bit_mode;
  logic wr_en;
  logic rd_en;
  logic tx_start;
  logic tx_event;
  logic rx_event;
  logic rx_store;
  frame_type rx_frame;

  tx_state_type tx_state_q;
  logic [10:0] tx_shift_q;
  logic [3:0] tx_bits_q;
  logic [4:0] tx_tick_q;

  rx_state_type rx_state_q;
  logic [8:0] rx_shift_q;
  logic [3:0] rx_bits_q;
  logic [4:0] rx_tick_q;

  function automatic logic [3:0] frame_bits(input logic [1:0] m);
    unique case (m)
      2'(uart_mode0): frame_bits = bits_mode0;
      2'(uart_mode1): frame_bits = bits_mode1;
      default: frame_bits = bits_mode23;
    endcase
  endfunction

  function automatic logic is_shift_mode(input logic [1:0] m);
    is_shift_mode = (m == 2'(uart_mode0));
  endfunction

  function automatic logic [4:0] bit_ticks(input logic [1:0] m);
    bit_ticks = is_shift_mode(m) ? shift_ticks : oversample;
  endfunction

  assign uart_mode = {serial_ctrl_reg_q.mode_hi, serial_ctrl_reg_q.mode_lo};
  assign nine_bit_mode = serial_ctrl_reg_q.mode_hi;
  assign wr_en = psel && penable && pwrite;
  // Read data is captured in the setup cycle
  assign rd_en = psel && !penable && !pwrite;
  assign tx_start = wr_en && paddr == tx_data_addr && tx_state_q == tx_idle;

  uart_rate_gen rate_gen (
    .sys_clk(sys_clk),
    .reset(reset),
    .timer1_run(timer1_run_q),
    .timer1_mode(timer_mode_reg_q[t1_mode_hi_bit:t1_mode_lo_bit]),
    .timer1_reload_high(reload_q),
    .uart_mode(uart_mode),
    .baud_double(power_ctrl_reg_q[baud_double_bit]),
    .tick(tick)
  );

  // Zero wait states: every access completes in its first access cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      prdata <= 32'h0;
    end else if (rd_en) begin
      unique case (paddr)
        power_control_addr: prdata <= {24'h0, power_ctrl_reg_q};
        timer_mode_select_addr: prdata <= {24'h0, timer_mode_reg_q};
        serial_control_addr: prdata <= {24'h0, serial_ctrl_reg_q};
        timer1_reload_addr: prdata <= {24'h0, reload_q};
        rx_data_addr: prdata <= {24'h0, rx_buf_q};
        irq_status_addr: prdata <= {30'h0, irq_status_q};
        irq_mask_addr: prdata <= {30'h0, irq_mask_q};
        timer1_ctrl_addr: prdata <= {31'h0, timer1_run_q};
        tx_data_addr: prdata <= {31'h0, tx_state_q != tx_idle};
        default: prdata <= 32'h0;
      endcase
    end
  end

  // A control write to the access cycle; pready there is the registered setup
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      power_ctrl_reg_q <= reg8_reset;
    end else if (wr_en && paddr == power_control_addr) begin
      power_ctrl_reg_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      timer_mode_reg_q <= reg8_reset;
    end else if (wr_en && paddr == timer_mode_select_addr) begin
      timer_mode_reg_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reload_q <= reload_reset;
    end else if (wr_en && paddr == timer1_reload_addr) begin
      reload_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      timer1_run_q <= 1'b0;
    end else if (wr_en && paddr == timer1_ctrl_addr) begin
      timer1_run_q <= pwdata[0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_mask_q <= irq_reset;
    end else if (wr_en && paddr == irq_mask_addr) begin
      irq_mask_q <= pwdata[1:0];
    end
  end

  // Done flags: hardware set wins over a software clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      serial_ctrl_reg_q <= serial_ctrl_type'(reg8_reset);
    end else begin
      if (wr_en && paddr == serial_control_addr) begin
        serial_ctrl_reg_q <= serial_ctrl_type'(pwdata[7:0]);
        serial_ctrl_reg_q.rx_ninth_bit <= rx_store && nine_bit_mode ?
          rx_frame.ninth : pwdata[rx_ninth_pos];
        serial_ctrl_reg_q.tx_done_flag <= tx_event | pwdata[tx_done_pos];
        serial_ctrl_reg_q.rx_done_flag <= rx_event | pwdata[rx_done_pos];
      end else begin
        if (tx_event) serial_ctrl_reg_q.tx_done_flag <= 1'b1;
        if (rx_event) serial_ctrl_reg_q.rx_done_flag <= 1'b1;
        if (rx_store && nine_bit_mode) serial_ctrl_reg_q.rx_ninth_bit <= rx_frame.ninth;
      end
    end
  end

  // Status bits: write one clears, a new event in the same cycle stays set
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_status_q <= irq_reset;
    end else begin
      irq_status_q <= (irq_status_q & ~((wr_en && paddr == irq_status_addr) ?
        pwdata[1:0] : 2'h0)) | {tx_event, rx_event};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) irq <= 1'b0;
    else irq <= |(irq_status_q & irq_mask_q);
  end

  // Transmitter; mode 0 shifts LSB first with no framing
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tx_state_q <= tx_idle;
      tx_shift_q <= 11'h7ff;
      tx_bits_q <= 4'h0;
      tx_tick_q <= 5'h0;
      tx_event <= 1'b0;
      txd <= 1'b1;
    end else begin
      tx_event <= 1'b0;
      unique case (tx_state_q)
        tx_idle: begin
          txd <= 1'b1;
          if (tx_start) begin
            tx_state_q <= tx_shift;
            tx_bits_q <= frame_bits(uart_mode);
            tx_tick_q <= 5'h0;
            if (is_shift_mode(uart_mode))
              tx_shift_q <= {3'h7, pwdata[7:0]};
            else if (nine_bit_mode)
              tx_shift_q <= {1'b1, serial_ctrl_reg_q.tx_ninth_bit, pwdata[7:0], 1'b0};
            else
              tx_shift_q <= {2'h3, pwdata[7:0], 1'b0};
          end
        end
        tx_shift: begin
          txd <= tx_shift_q[0];
          if (tick) begin
            if (tx_tick_q == bit_ticks(uart_mode) - 5'h1) begin
              tx_tick_q <= 5'h0;
              tx_shift_q <= {1'b1, tx_shift_q[10:1]};
              tx_bits_q <= tx_bits_q - 4'h1;
              if (tx_bits_q == 4'h1) begin
                tx_state_q <= tx_idle;
                tx_event <= 1'b1;
              end
            end else begin
              tx_tick_q <= tx_tick_q + 5'h1;
            end
          end
        end
        default: tx_state_q <= tx_idle;
      endcase
    end
  end

  // Shift clock for mode 0 toggles low during the first half of each bit
  always_ff @(posedge sys_clk) begin
    if (reset) shift_clk <= 1'b1;
    else shift_clk <= !(tx_state_q == tx_shift && is_shift_mode(uart_mode) &&
      tx_tick_q == 5'h0);
  end

  assign rx_frame.data = rx_shift_q[7:0];
  assign rx_frame.ninth = rx_shift_q[8];

  // Receiver in modes 1..3; ninth bit filter decides acceptance
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rx_state_q <= rx_idle;
      rx_shift_q <= 9'h0;
      rx_bits_q <= 4'h0;
      rx_tick_q <= 5'h0;
      rx_event <= 1'b0;
      rx_store <= 1'b0;
    end else begin
      rx_event <= 1'b0;
      rx_store <= 1'b0;
      unique case (rx_state_q)
        rx_idle: begin
          if (serial_ctrl_reg_q.rx_enable && !is_shift_mode(uart_mode) && !rxd) begin
            rx_state_q <= rx_start;
            rx_tick_q <= 5'h0;
          end
        end
        rx_start: begin
          if (tick) begin
            if (rx_tick_q == half_bit - 5'h1) begin
              rx_tick_q <= 5'h0;
              rx_state_q <= rxd ? rx_idle : rx_data;
              rx_bits_q <= frame_bits(uart_mode) - 4'h1;
            end else begin
              rx_tick_q <= rx_tick_q + 5'h1;
            end
          end
        end
        rx_data: begin
          if (tick) begin
            if (rx_tick_q == oversample - 5'h1) begin
              rx_tick_q <= 5'h0;
              rx_bits_q <= rx_bits_q - 4'h1;
              if (rx_bits_q == 4'h1) begin
                rx_state_q <= rx_idle;
                if (!(nine_bit_mode && serial_ctrl_reg_q.multiproc_filter &&
                      !rx_shift_q[8])) begin
                  rx_event <= 1'b1;
                  rx_store <= 1'b1;
                end
              end else if (nine_bit_mode) begin
                rx_shift_q <= {rxd, rx_shift_q[8:1]};
              end else begin
                rx_shift_q <= {1'b0, rxd, rx_shift_q[7:1]};
              end
            end else begin
              rx_tick_q <= rx_tick_q + 5'h1;
            end
          end
        end
        default: rx_state_q <= rx_idle;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) rx_buf_q <= reg8_reset;
    else if (rx_store) rx_buf_q <= rx_frame.data;
  end
endmodule // uart_timer1_baud

// ==== sim/uart_timer1_baud_chk.sv ====
// Assertion checker watching the serial port block at its ports
`timescale 1ns/1ps
module uart_timer1_baud_chk
  import uart_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rxd,
  input wire logic txd,
  input wire logic shift_clk,
  input wire logic irq
);
  logic [1:0] mask_q;
  logic rd_done;
  assign rd_done = pready && !pwrite;
  // Shadow of the mask, so irq can be tied to what software wrote
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mask_q <= irq_reset;
    end else if (pready && pwrite && paddr == irq_mask_addr) begin
      mask_q <= pwdata[1:0];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  pready_answer_a: assert property (psel && !penable |=> pready)
    else $error("no answer in access cycle");
  pready_single_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  no_error_a: assert property (pready |-> !pslverr)
    else $error("error response seen");
  reset_idle_a: assert property (disable iff (1'b0)
    reset |=> txd && shift_clk && !irq && !pready)
    else $error("outputs not idle after reset");
  read_width_a: assert property (rd_done |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  mask_read_a: assert property (rd_done && paddr == irq_mask_addr |-> prdata[1:0] == mask_q)
    else $error("mask readback wrong");
  irq_masked_a: assert property (mask_q == 2'h0 && $past(mask_q) == 2'h0 |-> !irq)
    else $error("irq high while masked");
  shift_pulse_a: assert property ($fell(shift_clk) |=> $rose(shift_clk))
    else $error("shift clock low too long");
  tx_start_c: cover property (pready && pwrite && paddr == tx_data_addr);
  irq_rise_c: cover property ($rose(irq));
  shift_c: cover property ($fell(shift_clk));
endmodule // uart_timer1_baud_chk
bind uart_timer1_baud uart_timer1_baud_chk uart_timer1_baud_chk_i (.sys_clk, .reset, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rxd, .txd, .shift_clk, .irq);

// ==== sim/serial_peer.sv ====
// Remote serial device: sends frames on rxd and samples frames from txd
`timescale 1ns/1ps
module serial_peer (
  input wire logic sys_clk,
  input wire logic txd,
  output logic rxd
);
  initial rxd = 1'b1;
  // Start bit, nb data bits least significant first, stop bit; line idles high
  task automatic send(input logic [8:0] f, input int nb, input int bl);
    @(posedge sys_clk);
    rxd <= 1'b0;
    repeat (bl) @(posedge sys_clk);
    for (int j = 0; j < nb; j++) begin
      rxd <= f[j];
      repeat (bl) @(posedge sys_clk);
    end
    rxd <= 1'b1;
    repeat (bl) @(posedge sys_clk);
  endtask
  // Samples each bit in its middle, as a remote receiver would
  task automatic recv(input int nb, input int bl, output logic [8:0] f);
    f = 9'h000;
    while (txd !== 1'b0) @(posedge sys_clk);
    repeat (bl / 2) @(posedge sys_clk);
    for (int j = 0; j < nb; j++) begin
      repeat (bl) @(posedge sys_clk);
      f[j] = txd;
    end
  endtask
endmodule // serial_peer

// ==== sim/uart_timer1_baud_test.sv ====
// Self-checking testbench for the serial port and its bit-rate timer
`timescale 1ns/1ps
module uart_timer1_baud_test;
  import uart_pkg::*;
  typedef struct {logic [7:0] tm, pc, sc, rl; int bl;} row_type;
  logic sys_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, rxd, txd, shift_clk, irq;
  logic [8:0] frm;
  int n_mismatch = 0;
  int num_checks = 0;
  int w;
  row_type r;
  // Timer mode, power control, serial control, reload, then clocks per bit
  row_type rows[6] = '{
    '{8'h20, 8'h00, 8'h80, 8'h00, 64},
    '{8'h20, 8'h80, 8'h88, 8'h00, 32},
    '{8'h20, 8'h7f, 8'h80, 8'h00, 64},
    '{8'h20, 8'h80, 8'h40, 8'hfc, 64},
    '{8'h20, 8'h00, 8'h40, 8'hfc, 128},
    '{8'h20, 8'hff, 8'hc8, 8'hfe, 32}
  };
  uart_timer1_baud uart_timer1_baud_i (.sys_clk, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rxd, .txd, .shift_clk, .irq);
  serial_peer serial_peer_i (.sys_clk, .txd, .rxd);
  // An idle edge first, so back-to-back calls never assign psel twice at once
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_irq(input int lim);
    for (int t = 0; t < lim && irq !== 1'b1; t++) @(posedge sys_clk);
  endtask
  // Width of the first data bit; data bit 0 must be one
  task automatic width(output int n);
    n = 0;
    while (txd !== 1'b0) @(posedge sys_clk);
    while (txd !== 1'b1) @(posedge sys_clk);
    while (txd === 1'b1) begin
      @(posedge sys_clk);
      n++;
    end
  endtask
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial forever #20 sys_clk = ~sys_clk;
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    final_report();
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    apb(0, serial_control_addr, 0);
    chk("serial_control reset", 0, rd);
    apb(0, 12'h3fc, 0);
    chk("unmapped", 0, rd);
    apb(1, timer1_ctrl_addr, 1);
    apb(1, irq_mask_addr, 3);
    foreach (rows[i]) begin
      r = rows[i];
      apb(1, timer_mode_select_addr, r.tm);
      apb(1, power_control_addr, r.pc);
      apb(1, timer1_reload_addr, r.rl);
      // Timer 1 takes the new reload only at an overflow; let it get there first
      repeat (300) @(posedge sys_clk);
      apb(1, serial_control_addr, r.sc);
      fork
        serial_peer_i.recv(r.sc[7] ? 9 : 8, r.bl, frm);
        width(w);
        apb(1, tx_data_addr, 32'h55);
      join
      chk("bit clocks", r.bl, w);
      chk("tx frame", {r.sc[7] & r.sc[3], 8'h55}, frm);
      wait_irq(300);
      chk("tx irq", 1, irq);
      apb(0, serial_control_addr, 0);
      chk("tx flag", r.sc | 8'h02, rd);
      apb(1, irq_status_addr, 3);
      apb(1, serial_control_addr, 0);
      chk("irq clear", 0, irq);
    end
    apb(1, power_control_addr, 8'h80);
    apb(1, timer1_reload_addr, 8'hfc);
    apb(1, serial_control_addr, 8'h40);
    serial_peer_i.send(9'h0a5, 8, 64);
    apb(0, irq_status_addr, 0);
    chk("rx disabled", 0, rd);
    apb(1, irq_mask_addr, 0);
    apb(1, serial_control_addr, 8'h50);
    serial_peer_i.send(9'h0a5, 8, 64);
    apb(0, rx_data_addr, 0);
    chk("rx data", 32'ha5, rd);
    chk("irq masked", 0, irq);
    apb(1, irq_mask_addr, 3);
    apb(0, irq_status_addr, 0);
    chk("rx status", 1, rd);
    chk("rx irq", 1, irq);
    apb(1, irq_status_addr, 3);
    apb(1, serial_control_addr, 8'hf0);
    serial_peer_i.send(9'h03c, 9, 64);
    apb(0, irq_status_addr, 0);
    chk("filtered", 0, rd);
    serial_peer_i.send(9'h13c, 9, 64);
    apb(0, serial_control_addr, 0);
    chk("rx ninth", 32'hf5, rd);
    apb(0, rx_data_addr, 0);
    chk("rx data 9", 32'h3c, rd);
    apb(1, irq_status_addr, 3);
    apb(1, serial_control_addr, 0);
    w = 0;
    frm = 9'h000;
    fork
      apb(1, tx_data_addr, 32'h96);
      repeat (40) begin
        @(posedge sys_clk);
        w += (shift_clk === 1'b0);
        // txd holds the bit while shift_clk is low
        if (shift_clk === 1'b0) frm = {txd, frm[8:1]};
      end
    join
    chk("shift pulses", 8, w);
    chk("shift data", 32'h96, frm[8:1]);
    reset <= 1'b1;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    chk("reset txd", 1, txd);
    chk("reset irq", 0, irq);
    apb(0, irq_mask_addr, 0);
    chk("mask reset", 0, rd);
    final_report();
  end
endmodule // uart_timer1_baud_test
